// >>> verilog/frlp_pkg.sv
/*
  Constants for the flash row latch programmer: widths, key values,
  the blank latch word and unlock timing.
  Assumes a 20 MHz system clock.
*/
package frlp_pkg;
  // ****************************************
  // geometry
  // ****************************************
  localparam int          ADDR_W       = 15;
  localparam int          ROW_W        = 10;
  localparam int          IDX_W        = 5;
  localparam int          WORD_W       = 14;
  localparam int          NUM_LATCH    = 32;
  localparam int          ADDR_HIGH_W  = 7;
  localparam int          DATA_HIGH_W  = 6;
  localparam logic [13:0] BLANK_WORD   = 14'h3FFF;
  localparam logic [4:0]  LAST_IDX     = 5'h1F;

  // ****************************************
  // unlock keys and timing
  // ****************************************
  localparam logic [7:0]  KEY_FIRST    = 8'h55;
  localparam logic [7:0]  KEY_SECOND   = 8'hAA;
  localparam int          CLK_HZ       = 20_000_000;
  localparam int          UNLOCK_GAP_NS = 200;
  // longest gap rounds down, never below one cycle
  localparam int          UNLOCK_GAP_RAW = (UNLOCK_GAP_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int          UNLOCK_GAP_CYC = (UNLOCK_GAP_RAW < 1) ? 1 : UNLOCK_GAP_RAW;
  localparam int          GAP_W        = 4;

  typedef enum logic [1:0] {UL_IDLE, UL_GOT_FIRST, UL_GOT_SECOND} frlp_unlock_e;
  typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_ISSUE, ST_WAIT, ST_ERASE, ST_CLEAR}
    frlp_state_e;
endpackage

// >>> verilog/frlp_latch_mem.sv
/*
  Bank of 32 write latches with a registered read port.
  A per-latch loaded bit lets the whole bank return to blank in one cycle.
*/
`timescale 1ns/1ps
module frlp_latch_mem
  import frlp_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              wr_en_i,
  input  wire logic [IDX_W-1:0]  wr_idx_i,
  input  wire logic [WORD_W-1:0] wr_data_i,
  input  wire logic [IDX_W-1:0]  rd_idx_i,
  input  wire logic              blank_all_i,
  output logic      [WORD_W-1:0] rd_data_o
);
  logic [WORD_W-1:0]    word_ff [NUM_LATCH];
  logic [NUM_LATCH-1:0] loaded_ff;

  wire [WORD_W-1:0] rd_word = loaded_ff[rd_idx_i] ? word_ff[rd_idx_i] : BLANK_WORD;

  always_ff @(posedge clk_i)
  begin
    if (wr_en_i)
    begin
      word_ff[wr_idx_i] <= wr_data_i;
    end
  end

  // clearing the loaded bits is cheaper than rewriting every word
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || blank_all_i)
    begin
      loaded_ff <= '0;
    end
    else if (wr_en_i)
    begin
      loaded_ff[wr_idx_i] <= 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      rd_data_o <= BLANK_WORD;
    end
    else
    begin
      rd_data_o <= rd_word;
    end
  end
endmodule

// >>> verilog/frlp_top.sv
/*
  Flash row latch programmer: unlock sequence checker, latch loading,
  row programming and row erase towards the program flash array.
  Assumes software-side control bits arrive as synchronous levels and
  strobes, and that the array acknowledges each word or erase with a pulse.
*/
// Functional notes
// - row is upper ten address bits; latch index is low five bits of low byte.
// - one program touches only one row; row is frozen at start.
// - every program or erase completion returns all latches to blank 3FFF.
// - programming never erases; erase is its own operation.
// - thirty-two latches per row; a program writes at most thirty-two words.
// - latch-only set: unlock sequence loads the addressed latch only.
// - latch-only clear: unlock loads final word then programs whole row.
// - broken unlock sequence aborts with no latch or flash effect.
// - erase works only on whole rows.
// - unlock is key 55h, key AAh, then go bit, in strict order.
// - completion sets done flag; interrupt when done enable is set.
`timescale 1ns/1ps
module frlp_top
  import frlp_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   sys_rst_i,
  input  wire logic                   program_enable_i,
  input  wire logic                   region_select_i,
  input  wire logic                   latch_only_select_i,
  input  wire logic                   erase_select_i,
  input  wire logic                   nv_done_irq_enable_i,
  input  wire logic [ADDR_HIGH_W-1:0] nv_addr_high_i,
  input  wire logic [7:0]             nv_addr_low_i,
  input  wire logic [DATA_HIGH_W-1:0] nv_data_high_i,
  input  wire logic [7:0]             nv_data_low_i,
  input  wire logic                   key_wr_i,
  input  wire logic [7:0]             key_data_i,
  input  wire logic                   go_set_i,
  input  wire logic                   done_clr_i,
  input  wire logic                   flash_ack_i,
  output logic                        prog_go_o,
  output logic                        nv_done_flag_o,
  output logic                        nv_done_irq_o,
  output logic                        flash_wr_req_o,
  output logic                        flash_erase_req_o,
  output logic      [ADDR_W-1:0]      flash_addr_o,
  output logic      [WORD_W-1:0]      flash_data_o
);
  // ****************************************
  // address and data split
  // ****************************************
  // row and latch index
  wire [ROW_W-1:0]  row_addr  = {nv_addr_high_i, nv_addr_low_i[7:5]};
  wire [IDX_W-1:0]  latch_idx = nv_addr_low_i[4:0];
  wire [WORD_W-1:0] data_word = {nv_data_high_i, nv_data_low_i};

  // ****************************************
  // unlock sequence
  // ****************************************
  frlp_unlock_e     ul_ff;
  frlp_unlock_e     nxt_ul;
  logic [GAP_W-1:0] gap_ff;
  frlp_state_e      st_ff;
  frlp_state_e      nxt_st;

  wire gap_ok     = (gap_ff < GAP_W'(UNLOCK_GAP_CYC));
  wire busy       = (st_ff != ST_IDLE) || prog_go_o;
  wire key_first  = key_wr_i && (key_data_i == KEY_FIRST);
  wire key_second = key_wr_i && (key_data_i == KEY_SECOND);
  // go only counts right after the two keys
  wire unlock_hit = (ul_ff == UL_GOT_SECOND) && go_set_i && gap_ok && !key_wr_i;
  // region select high targets other memories, which this block does not serve
  wire go_valid   = unlock_hit && program_enable_i && !region_select_i && !busy;

  always_comb
  begin
    nxt_ul = ul_ff;
    unique case (ul_ff)
      UL_IDLE:
        nxt_ul = key_first ? UL_GOT_FIRST : UL_IDLE;
      // a wrong key, stray go or long gap drops the sequence
      UL_GOT_FIRST:
        if (key_second && gap_ok && !go_set_i)
          nxt_ul = UL_GOT_SECOND;
        else if (key_wr_i || go_set_i || !gap_ok)
          nxt_ul = key_first ? UL_GOT_FIRST : UL_IDLE;
      UL_GOT_SECOND:
        if (key_wr_i || go_set_i || !gap_ok)
          nxt_ul = key_first ? UL_GOT_FIRST : UL_IDLE;
    endcase
  end

  wire ul_step = (nxt_ul != ul_ff) || key_wr_i;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ul_ff  <= UL_IDLE;
      gap_ff <= '0;
    end
    else
    begin
      ul_ff  <= nxt_ul;
      gap_ff <= ul_step ? '0 : (gap_ok ? gap_ff + GAP_W'(1) : gap_ff);
    end
  end

  // ****************************************
  // latch bank
  // ****************************************
  logic [IDX_W-1:0]  idx_ff;
  logic [ROW_W-1:0]  row_ff;
  logic [WORD_W-1:0] rd_data;

  // a valid unlock always loads the addressed latch, unless erasing
  wire latch_wr  = go_valid && !erase_select_i;
  // blank every latch when program or erase finishes
  wire blank_all = (st_ff == ST_CLEAR);

  frlp_latch_mem u_latch (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .wr_en_i     (latch_wr),
    .wr_idx_i    (latch_idx),
    .wr_data_i   (data_word),
    .rd_idx_i    (idx_ff),
    .blank_all_i (blank_all),
    .rd_data_o   (rd_data)
  );

  // ****************************************
  // operation sequencer
  // ****************************************
  always_comb
  begin
    nxt_st = st_ff;
    unique case (st_ff)
      ST_IDLE:
        // erase is row wide; program never erases
        if (go_valid && erase_select_i)
          nxt_st = ST_ERASE;
        // last word loaded, then the whole row goes out
        else if (go_valid && !latch_only_select_i)
          nxt_st = ST_FETCH;
      ST_FETCH:
        nxt_st = ST_ISSUE;
      ST_ISSUE:
        nxt_st = ST_WAIT;
      ST_WAIT:
        if (flash_ack_i)
          nxt_st = (idx_ff == LAST_IDX) ? ST_CLEAR : ST_FETCH;
      ST_ERASE:
        if (flash_ack_i)
          nxt_st = ST_CLEAR;
      ST_CLEAR:
        nxt_st = ST_IDLE;
      default:
        nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      st_ff  <= ST_IDLE;
      idx_ff <= '0;
      row_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
      // row frozen for the whole operation
      if (go_valid)
      begin
        row_ff <= row_addr;
        idx_ff <= '0;
      end
      else if ((st_ff == ST_WAIT) && flash_ack_i && (idx_ff != LAST_IDX))
      begin
        idx_ff <= idx_ff + IDX_W'(1);
      end
    end
  end

  // ****************************************
  // array requests and status
  // ****************************************
  wire op_done = (st_ff == ST_CLEAR);
  // latch-only loads finish in the cycle after the go bit is taken
  wire load_done = prog_go_o && (st_ff == ST_IDLE);

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      flash_wr_req_o    <= 1'b0;
      flash_erase_req_o <= 1'b0;
      flash_addr_o      <= '0;
      flash_data_o      <= BLANK_WORD;
    end
    else
    begin
      if (st_ff == ST_ISSUE)
      begin
        flash_wr_req_o <= 1'b1;
        flash_addr_o   <= {row_ff, idx_ff};
        flash_data_o   <= rd_data;
      end
      else if (flash_ack_i)
      begin
        flash_wr_req_o <= 1'b0;
      end
      if (go_valid && erase_select_i)
      begin
        flash_erase_req_o <= 1'b1;
        flash_addr_o      <= {row_addr, IDX_W'(0)};
      end
      else if (flash_ack_i)
      begin
        flash_erase_req_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      prog_go_o      <= 1'b0;
      nv_done_flag_o <= 1'b0;
      nv_done_irq_o  <= 1'b0;
    end
    else
    begin
      // go held through the operation, cleared by hardware
      // idle with go high can only be a latch load, so the clear must not
      // depend on latch-only: software may flip it right after the go
      if (go_valid)
        prog_go_o <= 1'b1;
      else if (op_done || load_done)
        prog_go_o <= 1'b0;
      // set wins over a simultaneous clear
      if (op_done)
        nv_done_flag_o <= 1'b1;
      else if (done_clr_i)
        nv_done_flag_o <= 1'b0;
      nv_done_irq_o <= (op_done || (nv_done_flag_o && !done_clr_i)) && nv_done_irq_enable_i;
    end
  end
endmodule

// >>> verif/frlp_flash_model.sv
/*
  Behavioural program flash array: acks word writes and row erases.
  Assumes each request holds until its ack and only one is open.
*/
`timescale 1ns/1ps
module frlp_flash_model
  import frlp_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              wr_req_i,
  input  wire logic              erase_req_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [WORD_W-1:0] data_i,
  input  wire logic [3:0]        dly_i,
  output logic                   ack_o
);
  // ****************************************
  // ack timing and capture
  // ****************************************
  int                cnt  = 0;
  int                wcnt = 0;
  int                ecnt = 0;
  logic [WORD_W-1:0] wdat [NUM_LATCH];
  logic [ROW_W-1:0]  wrow;
  initial ack_o = 1'b0;
  always @(posedge clk_i)
  begin
    ack_o <= 1'b0;
    if ((wr_req_i || erase_req_i) && !ack_o)
    begin
      cnt   <= (cnt >= dly_i) ? 0 : cnt + 1;
      ack_o <= (cnt >= dly_i);
    end
    // one word per ack, row kept
    if (ack_o && wr_req_i)
    begin
      wdat[addr_i[IDX_W-1:0]] <= data_i;
      wrow                    <= addr_i[ADDR_W-1:IDX_W];
      wcnt                    <= wcnt + 1;
    end
    if (ack_o && erase_req_i)
      ecnt <= ecnt + 1;
  end
endmodule

// >>> verif/frlp_top_sva.sv
/*
  Port assertions for the row programmer.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module frlp_top_sva
  import frlp_pkg::*;
(
  input wire logic                   clk_i,
  input wire logic                   sys_rst_i,
  input wire logic                   program_enable_i,
  input wire logic                   region_select_i,
  input wire logic                   latch_only_select_i,
  input wire logic                   erase_select_i,
  input wire logic                   nv_done_irq_enable_i,
  input wire logic [ADDR_HIGH_W-1:0] nv_addr_high_i,
  input wire logic [7:0]             nv_addr_low_i,
  input wire logic                   key_wr_i,
  input wire logic [7:0]             key_data_i,
  input wire logic                   go_set_i,
  input wire logic                   flash_ack_i,
  input wire logic                   prog_go_o,
  input wire logic                   nv_done_flag_o,
  input wire logic                   nv_done_irq_o,
  input wire logic                   flash_wr_req_o,
  input wire logic                   flash_erase_req_o,
  input wire logic [ADDR_W-1:0]      flash_addr_o,
  input wire logic [WORD_W-1:0]      flash_data_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wire              req_any = flash_wr_req_o || flash_erase_req_o;
  // row of the last go, refused ones carry the same address here
  logic [ROW_W-1:0] row_ff;
  always_ff @(posedge clk_i)
    if (go_set_i)
      row_ff <= {nv_addr_high_i, nv_addr_low_i[7:5]};
  // ****************************************
  // properties
  // ****************************************
  property p_load;
    key_wr_i && key_data_i == KEY_FIRST ##1 key_wr_i && key_data_i == KEY_SECOND
    ##1 go_set_i && !key_wr_i && program_enable_i && !region_select_i
    && latch_only_select_i && !erase_select_i && !prog_go_o
    |=> prog_go_o ##1 !prog_go_o && !req_any;
  endproperty
  a_load: assert property (p_load) else $error("latch load go pulse wrong");
  property p_cause;
    $rose(prog_go_o) |-> $past(go_set_i) && $past(program_enable_i) && !$past(region_select_i);
  endproperty
  a_cause: assert property (p_cause) else $error("go set without valid go");
  property p_row;
    req_any |-> flash_addr_o[ADDR_W-1:IDX_W] == row_ff;
  endproperty
  a_row: assert property (p_row) else $error("request outside the row");
  property p_hold;
    req_any && !flash_ack_i |=> req_any && $stable(flash_addr_o) && $stable(flash_data_o);
  endproperty
  a_hold: assert property (p_hold) else $error("request changed before ack");
  property p_drop;
    req_any && flash_ack_i |=> !req_any;
  endproperty
  a_drop: assert property (p_drop) else $error("request held after ack");
  property p_end;
    flash_ack_i && (flash_erase_req_o || flash_wr_req_o && flash_addr_o[IDX_W-1:0] == LAST_IDX)
    |=> prog_go_o ##1 nv_done_flag_o && !prog_go_o;
  endproperty
  a_end: assert property (p_end) else $error("completion timing wrong");
  property p_irq;
    $rose(nv_done_flag_o) |-> nv_done_irq_o == $past(nv_done_irq_enable_i);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt does not follow enable");
  property p_erase;
    flash_erase_req_o |-> flash_addr_o[IDX_W-1:0] == 5'h00 && !flash_wr_req_o;
  endproperty
  a_erase: assert property (p_erase) else $error("erase not row aligned");
  c_erase: cover property (flash_erase_req_o && flash_ack_i);
  c_done:  cover property ($rose(nv_done_flag_o));
  c_irq:   cover property ($rose(nv_done_irq_o));
endmodule
bind frlp_top frlp_top_sva sva (.*);

// >>> verif/tb_top.sv
/*
  Self-checking bench for the row programmer and its flash model.
  Assumes a 20 MHz clock and software-side strobes one cycle long.
*/
`timescale 1ns/1ps
module tb_top;
  import frlp_pkg::*;
  logic clk_i, sys_rst_i, program_enable_i, region_select_i, latch_only_select_i;
  logic erase_select_i, nv_done_irq_enable_i, key_wr_i, go_set_i, done_clr_i, flash_ack_i;
  logic prog_go_o, nv_done_flag_o, nv_done_irq_o, flash_wr_req_o, flash_erase_req_o;
  logic [ADDR_HIGH_W-1:0] nv_addr_high_i;
  logic [DATA_HIGH_W-1:0] nv_data_high_i;
  logic [7:0]             nv_addr_low_i, nv_data_low_i, key_data_i;
  logic [ADDR_W-1:0]      flash_addr_o;
  logic [WORD_W-1:0]      flash_data_o;
  logic [3:0]             dly;
  int                     bad_count = 0;
  int                     checked   = 0;
  frlp_top dut (.*);
  frlp_flash_model fm (.clk_i(clk_i), .wr_req_i(flash_wr_req_o), .erase_req_i(flash_erase_req_o),
    .addr_i(flash_addr_o), .data_i(flash_data_o), .dly_i(dly), .ack_o(flash_ack_i));
  always #25 clk_i = ~clk_i;
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    if (bad_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      #1;
    end
  endtask
  // first key, second key, gap, then go
  task automatic unlock(input logic [7:0] k2, input int gap);
    key_wr_i = 1'b1;
    key_data_i = KEY_FIRST;
    tick(1);
    key_data_i = k2;
    tick(1);
    key_wr_i = 1'b0;
    tick(gap);
    go_set_i = 1'b1;
    tick(1);
    go_set_i = 1'b0;
  endtask
  task automatic load(input logic [4:0] idx, input logic [13:0] w);
    nv_addr_low_i = {3'h5, idx};
    {nv_data_high_i, nv_data_low_i} = w;
    unlock(KEY_SECOND, 0);
  endtask
  task automatic finish_op(input logic ien);
    int n = 0;
    while (nv_done_flag_o !== 1'b1 && n < 3000)
    begin
      tick(1);
      n++;
    end
    if (nv_done_flag_o !== 1'b1)
    begin
      bad_count++;
      stop_test();
    end
    chk(nv_done_irq_o, ien);
    chk(prog_go_o, 1'b0);
    done_clr_i = 1'b1;
    tick(1);
    done_clr_i = 1'b0;
    chk(nv_done_flag_o, 1'b0);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  // loaded latch must be blanked by the erase erase before program
  task automatic s_erase;
    latch_only_select_i = 1'b1;
    load(5'h03, 14'h0777);
    tick(1);
    erase_select_i = 1'b1;
    latch_only_select_i = 1'b0;
    load(5'h07, 14'h0000);
    finish_op(1'b1);
    chk(fm.ecnt, 1);
    chk(fm.wcnt, 0);
    erase_select_i = 1'b0;
  endtask
  task automatic s_refuse;
    latch_only_select_i = 1'b1;
    load(5'h02, 14'h0555);
    chk(prog_go_o, 1'b1);
    tick(1);
    unlock(KEY_SECOND, 3);
    chk(prog_go_o, 1'b1);
    tick(1);
    // refused requests aim at an unused latch, which must stay blank
    nv_addr_low_i = {3'h5, 5'h09};
    {nv_data_high_i, nv_data_low_i} = 14'h0AAA;
    unlock(8'h00, 0);
    chk(prog_go_o, 1'b0);
    unlock(KEY_FIRST, 0);
    chk(prog_go_o, 1'b0);
    unlock(KEY_SECOND, 6);
    chk(prog_go_o, 1'b0);
    region_select_i = 1'b1;
    unlock(KEY_SECOND, 0);
    chk(prog_go_o, 1'b0);
    region_select_i = 1'b0;
    program_enable_i = 1'b0;
    unlock(KEY_SECOND, 0);
    chk(prog_go_o, 1'b0);
    program_enable_i = 1'b1;
  endtask
  task automatic s_program(input int nload, input logic [3:0] d, input logic ien);
    int base;
    base = fm.wcnt;
    dly = d;
    nv_done_irq_enable_i = ien;
    latch_only_select_i = 1'b1;
    for (int i = 0; i < nload; i++)
    begin
      load(i[4:0], 14'h0123 + i[13:0]);
      chk(prog_go_o, 1'b1);
      tick(1);
      chk(prog_go_o || flash_wr_req_o, 1'b0);
    end
    // clear latch-only for the last word
    latch_only_select_i = 1'b0;
    load(LAST_IDX, 14'h1ABC);
    finish_op(ien);
    chk(fm.wcnt - base, NUM_LATCH);
    chk(fm.wrow, {7'h2A, 3'h5});
    for (int i = 0; i < 31; i++)
      chk(fm.wdat[i], (i < nload) ? 32'h0123 + i : BLANK_WORD);
    chk(fm.wdat[31], 14'h1ABC);
    chk(fm.ecnt, 1);
  endtask
  initial
  begin
    {clk_i, region_select_i, erase_select_i, key_wr_i, go_set_i, done_clr_i} = 6'h00;
    {sys_rst_i, program_enable_i, latch_only_select_i, nv_done_irq_enable_i} = 4'hF;
    {nv_addr_high_i, nv_addr_low_i, nv_data_high_i, nv_data_low_i} = {7'h2A, 8'hA0, 14'h0000};
    {key_data_i, dly} = 12'h000;
    tick(2);
    sys_rst_i = 1'b0;
    chk(flash_data_o, BLANK_WORD);
    chk({prog_go_o, nv_done_flag_o, flash_wr_req_o}, 3'h0);
    s_erase();
    s_refuse();
    s_program(3, 4'h0, 1'b1);
    s_program(0, 4'h3, 1'b0);
    stop_test();
  end
endmodule
